// ==== ubmf_break_match_flags_ctrl.sv ====
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module ubmf_break_match_flags_ctrl (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic [3:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [3:0]             avs_byteenable,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	input  wire ubmf_pkg::ubmf_match_t  match_i,
	output logic                        break_req_a,
	output logic      [2:0]             flags_o,
	output logic                        irq
);

	typedef struct packed {
		ubmf_pkg::ubmf_state_t st;
		logic [2:0]            flags;
		logic                  irq_dis_a;
		logic [2:0]            mask;
		logic [31:0]           rdata;
	} ubmf_regs_t;

	ubmf_regs_t r_q;
	ubmf_regs_t r_d;

	ubmf_pkg::ubmf_avl_req_t req;
	logic [2:0]              ev;
	wire logic [2:0]         wz;
	wire logic [2:0]         flag_nxt;
	logic [2:0]              status;
	logic [2:0]              st_clr;
	logic [2:0]              pend;
	logic                    acc;
	logic                    sel_bc;
	logic                    sel_st;
	logic                    sel_mk;
	logic                    wr_bc;
	logic                    wr_dis;
	logic                    wr_mask;
	logic                    rd_acc;
	logic                    chan_a_hit;

	//////////////////////////////////////////////////////////////////////////
	// word address match
	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a[3:2] == o[3:2]);
	endfunction

	// byte lane that carries a bit position
	function automatic logic lane_on(input logic [3:0] be, input int pos);
		lane_on = be[pos[4:3]];
	endfunction

	// flag index to its bit in the control word
	function automatic int flag_pos(input int idx);
		case (idx)
			0:       flag_pos = ubmf_pkg::BIT_PB_FLAG_A;
			1:       flag_pos = ubmf_pkg::BIT_PB_FLAG_B;
			default: flag_pos = ubmf_pkg::BIT_IB_FLAG_A;
		endcase
	endfunction

	// match pulses in status bit order
	function automatic logic [2:0] ev_of(input ubmf_pkg::ubmf_match_t m);
		ev_of                        = 3'h0;
		ev_of[ubmf_pkg::BIT_EV_PB_A] = m.pb_a;
		ev_of[ubmf_pkg::BIT_EV_PB_B] = m.pb_b;
		ev_of[ubmf_pkg::BIT_EV_IB_A] = m.ib_a;
	endfunction

	// break control word as software reads it
	function automatic logic [31:0] bc_word(input logic dis, input logic [2:0] fl);
		logic [31:0] w;
		w = ubmf_pkg::RD_UNMAPPED;
		w[ubmf_pkg::BIT_RSVD_HI]   = 1'b0;
		w[ubmf_pkg::BIT_RSVD_LO]   = 1'b0;
		w[ubmf_pkg::BIT_IRQ_DIS_A] = dis;
		for (int k = 0; k < 3; k++) begin
			w[flag_pos(k)] = fl[k];
		end
		bc_word = w;
	endfunction

	// status and mask sit in the low bits
	function automatic logic [31:0] low_word(input logic [2:0] v);
		low_word      = ubmf_pkg::RD_UNMAPPED;
		low_word[2:0] = v;
	endfunction

	// read data of the addressed word
	function automatic logic [31:0] read_word(input logic [3:0] a, input ubmf_regs_t r, input logic [2:0] s);
		read_word = ubmf_pkg::RD_UNMAPPED;
		if (hit(a, ubmf_pkg::OFS_BREAK_CONTROL)) begin
			read_word = bc_word(r.irq_dis_a, r.flags);
		end else if (hit(a, ubmf_pkg::OFS_IRQ_STATUS)) begin
			read_word = low_word(s);
		end else if (hit(a, ubmf_pkg::OFS_IRQ_MASK)) begin
			read_word = low_word(r.mask);
		end
	endfunction

	// one wait cycle per accepted request
	function automatic ubmf_pkg::ubmf_state_t nxt_state(input ubmf_pkg::ubmf_state_t s, input logic take);
		unique case (s)
			ubmf_pkg::UBMF_IDLE: begin
				nxt_state = take ? ubmf_pkg::UBMF_RESP : ubmf_pkg::UBMF_IDLE;
			end
			ubmf_pkg::UBMF_RESP: begin
				nxt_state = ubmf_pkg::UBMF_IDLE;
			end
			default: begin
				nxt_state = ubmf_pkg::UBMF_IDLE;
			end
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	assign req = '{
		read:       avs_read,
		write:      avs_write,
		address:    avs_address,
		byteenable: avs_byteenable,
		writedata:  avs_writedata
	};

	// accept in idle, answer one cycle later
	assign acc             = (req.read | req.write) && (r_q.st == ubmf_pkg::UBMF_IDLE);
	assign avs_waitrequest = (req.read | req.write) && (r_q.st == ubmf_pkg::UBMF_IDLE);

	// bus decode
	assign sel_bc  = hit(req.address, ubmf_pkg::OFS_BREAK_CONTROL);
	assign sel_st  = hit(req.address, ubmf_pkg::OFS_IRQ_STATUS);
	assign sel_mk  = hit(req.address, ubmf_pkg::OFS_IRQ_MASK);
	assign wr_bc   = acc && req.write && sel_bc;
	assign wr_dis  = wr_bc && lane_on(req.byteenable, ubmf_pkg::BIT_IRQ_DIS_A);
	assign wr_mask = acc && req.write && sel_mk && lane_on(req.byteenable, ubmf_pkg::BIT_EV_PB_A);
	assign rd_acc  = acc && req.read;

	assign ev = ev_of(match_i);

	// read of status clears it
	assign st_clr = (rd_acc && sel_st) ? 3'h7 : 3'h0;

	// status latch, event wins over clear
	ubmf_event_latch u_status (
		.clk   (clk),
		.rst   (rst),
		.set_i (ev),
		.clr_i (st_clr),
		.q     (status)
	);

	//////////////////////////////////////////////////////////////////////////
	// per-flag clear and set
	generate
		for (genvar g = 0; g < 3; g++) begin : g_flag
			assign wz[g] = wr_bc && lane_on(req.byteenable, flag_pos(g)) && !req.writedata[flag_pos(g)];
			assign flag_nxt[g] = (r_q.flags[g] & ~wz[g]) | ev[g];
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// register next values
	always_comb begin
		r_d    = r_q;
		r_d.st = nxt_state(r_q.st, acc);
		if (wr_dis) begin
			r_d.irq_dis_a = req.writedata[ubmf_pkg::BIT_IRQ_DIS_A];
		end
		if (wr_mask) begin
			r_d.mask = req.writedata[2:0];
		end
		r_d.flags = flag_nxt;
		r_d.rdata = ubmf_pkg::RD_UNMAPPED;
		if (rd_acc) begin
			r_d.rdata = read_word(req.address, r_q, status);
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_q.st        <= ubmf_pkg::UBMF_IDLE;
			r_q.flags     <= ubmf_pkg::RST_FLAGS;
			r_q.irq_dis_a <= ubmf_pkg::RST_IRQ_DIS;
			r_q.mask      <= ubmf_pkg::RST_MASK;
			r_q.rdata     <= ubmf_pkg::RD_UNMAPPED;
		end else begin
			r_q <= r_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs
	assign avs_readdata = r_q.rdata;
	assign flags_o      = r_q.flags;
	assign chan_a_hit   = match_i.pb_a | match_i.ib_a;
	assign break_req_a  = chan_a_hit & ~r_q.irq_dis_a;
	assign pend         = status & r_q.mask;
	assign irq          = |pend;

endmodule

// ==== ubmf_pkg.sv ====
package ubmf_pkg;

	// register byte offsets
	localparam logic [3:0] OFS_BREAK_CONTROL = 4'h0;
	localparam logic [3:0] OFS_IRQ_STATUS    = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK      = 4'h8;

	// break control field positions
	localparam int BIT_RSVD_HI    = 18;
	localparam int BIT_IRQ_DIS_A  = 17;
	localparam int BIT_RSVD_LO    = 16;
	localparam int BIT_PB_FLAG_A  = 15;
	localparam int BIT_PB_FLAG_B  = 14;
	localparam int BIT_IB_FLAG_A  = 13;

	// status / mask field positions
	localparam int BIT_EV_PB_A = 0;
	localparam int BIT_EV_PB_B = 1;
	localparam int BIT_EV_IB_A = 2;

	// reset values
	localparam logic [2:0]  RST_FLAGS   = 3'h0;
	localparam logic        RST_IRQ_DIS = 1'b0;
	localparam logic [2:0]  RST_STATUS  = 3'h0;
	localparam logic [2:0]  RST_MASK    = 3'h0;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	typedef enum logic [1:0] {
		UBMF_IDLE = 2'b01,
		UBMF_RESP = 2'b10
	} ubmf_state_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [3:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} ubmf_avl_req_t;

	// match pulses from the break comparators
	typedef struct packed {
		logic pb_a;
		logic pb_b;
		logic ib_a;
	} ubmf_match_t;

endpackage

// ==== ubmf_event_latch.sv ====
`timescale 1ns/1ps
module ubmf_event_latch (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] set_i,
	input  wire logic [2:0] clr_i,
	output logic      [2:0] q
);

	typedef struct packed {
		logic [2:0] bits;
	} ubmf_latch_t;

	ubmf_latch_t st_q;
	ubmf_latch_t st_d;

	always_comb begin
		st_d = st_q;
		// set wins over clear
		st_d.bits = (st_q.bits & ~clr_i) | set_i;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q.bits <= ubmf_pkg::RST_STATUS;
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.bits;

endmodule

// ==== ubmf_assertions.sv ====
`timescale 1ns/1ps
module ubmf_assertions (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic [3:0]            avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic [3:0]            avs_byteenable,
	input wire logic [31:0]           avs_writedata,
	input wire logic [31:0]           avs_readdata,
	input wire logic                  avs_waitrequest,
	input wire ubmf_pkg::ubmf_match_t match_i,
	input wire logic                  break_req_a,
	input wire logic [2:0]            flags_o,
	input wire logic                  irq
);
	wire bc_wr = avs_write && avs_address[3:2] == 2'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_pba_sets: assert property (match_i.pb_a |=> flags_o[0]) else $error("pb_a flag");
	a_pbb_sets: assert property (match_i.pb_b |=> flags_o[1]) else $error("pb_b flag");
	a_iba_sets: assert property (match_i.ib_a |=> flags_o[2]) else $error("ib_a flag");
	a_req_cause: assert property (break_req_a |-> match_i.pb_a || match_i.ib_a) else $error("req");
	a_rsvd_zero: assert property (avs_read && !avs_waitrequest |-> !avs_readdata[18] && !avs_readdata[16]) else $error("rsvd");
	a_fall_cause: assert property (|($past(flags_o) & ~flags_o) |-> $past(bc_wr)) else $error("clear");
	a_one_keeps: assert property (bc_wr && avs_writedata[15] && flags_o[0] |=> flags_o[0]) else $error("keep");
	a_reset_zero: assert property ($fell(rst) |-> flags_o == 3'h0) else $error("reset");
endmodule
bind ubmf_break_match_flags_ctrl ubmf_assertions i_ubmf_assertions (.*);

// ==== ubmf_break_match_flags_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module ubmf_break_match_flags_ctrl_tb_top;
	logic                  clk = 0, rst = 1, rd = 0, wr = 0, req_a, irq, wt;
	logic [3:0]            adr = 0;
	logic [31:0]           wd = 0, rdat, m;
	logic [2:0]            fl;
	ubmf_pkg::ubmf_match_t mt = 0;
	int                    err_total = 0, checks_done = 0, seed = 88411;
	logic [31:0]           exp_q[$];
	always #25 clk = ~clk;
	ubmf_break_match_flags_ctrl i_ubmf_break_match_flags_ctrl (.clk(clk), .rst(rst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_byteenable(4'hf), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wt), .match_i(mt), .break_req_a(req_a), .flags_o(fl), .irq(irq));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok);
		checks_done++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t mismatch", $time);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		if (!w)
			exp_q.push_back(d);
		@(posedge clk iff !wt);
		rd <= 0;
		wr <= 0;
	endtask
	task automatic give_verdict;
		$display("errors %0d checks %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) if (rd && !wt) chk(rdat === exp_q.pop_front());
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		bus(0, 0, 32'h0);
		bus(1, 0, 32'h0002_e000);
		bus(0, 0, 32'h0002_0000);
		for (int i = 0; i < 4; i++) begin
			m = $random(seed);
			bus(1, 8, i ? 32'h0000_0007 : 32'h0);
			bus(1, 0, i[0] ? 32'h0002_0000 : 32'h0);
			@(posedge clk);
			mt <= m[2:0];
			@(posedge clk);
			chk(req_a === ((m[2] | m[0]) & !i[0]));
			mt <= 0;
			bus(1, 0, {14'h0, i[0], 1'b0, 3'h7, 13'h0});
			chk(fl === {m[0], m[1], m[2]});
			bus(0, 0, {14'h0, i[0], 1'b0, m[2:0], 13'h0});
			chk(irq === (i != 0 && |m[2:0]));
			bus(0, 4, {29'h0, m[0], m[1], m[2]});
			chk(irq === 1'b0);
			bus(1, 0, 32'h0);
			chk(fl === 3'h0);
			bus(0, 0, 32'h0);
		end
		bus(0, 12, 32'h0);
		give_verdict;
	end
	initial begin
		repeat (1000) @(posedge clk);
		err_total++;
		give_verdict;
	end
endmodule
